/* common/cpt_pkg.sv */
// Constants shared by the charge phase, status and pre-charge timer logic.
// Assumes one 125 MHz clock; analog comparators arrive as synchronous levels.
// Functional notes
// - Precharge lights both indicators, fast only A, done only B.
// - Charger off or input overvoltage turns both indicators off.
// - Above low voltage threshold the fast-charge current is selected.
// - Below low voltage threshold precharge current, about a tenth.
// - At regulation threshold enter voltage regulation, current tapers.
// - Pre-charge timer runs in conditioning, timeout a factor of t_chg.
// - Timer counts only charging, timer pin wired, output below threshold.
// - Timer reset in standby, pin open, or output above threshold.
// - Suspend below threshold holds the count; charging resumes it.
// - Expiry below threshold turns charger off and latches a fault.
// - Fault, power present, output low: recovery trickle current on.
// - Fault cleared by enable rising, overvoltage, power loss, timer off.
// - Near 112 C junction enter thermal regulation, reduce current.
// - Suspend above 155 C, resume about 20 C below it.
// - Thermal regulation slows the timer clock, stretching timeouts.
// - Timeouts come from a 2^24 span counter on the oscillator.
// - Stretch ratio: set over current-set in fast, pre-set over set in pre.
// - Deglitch timers use the same stretched oscillator tick; this design has no deglitch timers.
// - Pack temperature outside window suspends without resetting timers.
// - Termination disabled: never done, fast or precharge by voltage.
package cpt_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// Base oscillator period, arbitrary plain default
	localparam int OSC_PERIOD_NS = 800;
	localparam int OSC_DIV_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int TMR_WIDTH = 24;
	localparam logic [23:0] PCHG_TC_RESET = 24'h199999;
	localparam int RATIO_WIDTH = 4;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PCHG_TC = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;

	localparam int CTRL_TERM_EN_BIT = 0;
	localparam int CTRL_STRETCH_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;

	localparam int ST_MODE_LSB = 0;
	localparam int ST_PHASE_LSB = 4;
	localparam int ST_FAULT_BIT = 8;
	localparam int ST_SHUT_BIT = 9;
	localparam int ST_TREG_BIT = 10;
	localparam int ST_IND_A_BIT = 11;
	localparam int ST_IND_B_BIT = 12;
	localparam int ST_TRICKLE_BIT = 13;

	localparam logic [1:0] CUR_OFF = 2'h0;
	localparam logic [1:0] CUR_PRE = 2'h1;
	localparam logic [1:0] CUR_FAST = 2'h2;
	localparam logic [1:0] CUR_VREG = 2'h3;

	typedef enum logic [2:0] {
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_CHARGING,
		MODE_SUSPEND,
		MODE_FAULT
	} cpt_mode_t;

	typedef enum logic [1:0] {
		PHASE_PRE,
		PHASE_FAST,
		PHASE_VREG
	} cpt_phase_t;
endpackage : cpt_pkg

/* core/cpt_clock_stretch.sv */
// Timer oscillator with a period stretched by an integer multiplier.
// Assumes the multiplier is a synchronous level; zero is treated as one.
module cpt_clock_stretch
	import cpt_pkg::*;
#(
	parameter int DIV_CYCLES = OSC_DIV_CYCLES,
	parameter int MULT_WIDTH = RATIO_WIDTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [MULT_WIDTH-1:0] i_mult,
	output logic o_tick
);
	logic [15:0] div_reg;
	logic [MULT_WIDTH-1:0] sub_reg;
	logic base_wrap;
	logic [MULT_WIDTH-1:0] mult_eff;

	assign base_wrap = (div_reg == 16'(DIV_CYCLES - 1));
	// A zero ratio would stall the timers forever, so clamp to one
	assign mult_eff = (i_mult == '0) ? MULT_WIDTH'(1) : i_mult;

	always_ff @(posedge i_clk) begin
		if (i_rst || base_wrap) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// Each base period counts once; the tick comes after mult of them
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sub_reg <= '0;
			o_tick <= 1'b0;
		end else if (base_wrap) begin
			if (sub_reg >= mult_eff - MULT_WIDTH'(1)) begin
				sub_reg <= '0;
				o_tick <= 1'b1;
			end else begin
				sub_reg <= sub_reg + MULT_WIDTH'(1);
				o_tick <= 1'b0;
			end
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule : cpt_clock_stretch

/* core/cpt_charge_ctrl.sv */
// Charge phase selection, status indicators, pre-charge safety timer,
// thermal decisions and dynamic timer stretch, with an APB register slave.
// Assumes analog comparator results are synchronous to I_CLK.
//
// Local design decisions: the register addresses and the APB slave port.
module cpt_charge_ctrl
	import cpt_pkg::*;
#(
	parameter logic [TMR_WIDTH-1:0] PCHG_TC_DEFAULT = PCHG_TC_RESET
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_POWER_OK,
	input wire logic I_INPUT_OVERVOLTAGE,
	input wire logic I_CHARGE_ENABLE_N,
	input wire logic I_TIMER_PROGRAM_OPEN,
	input wire logic I_VOUT_ABOVE_LOWV,
	input wire logic I_VOUT_AT_REG,
	input wire logic I_PACK_TEMP_OK,
	input wire logic I_TJ_AT_REG,
	input wire logic I_TJ_OVER_SHUT,
	input wire logic I_TJ_BELOW_RESUME,
	input wire logic I_TERM_DONE,
	input wire logic [RATIO_WIDTH-1:0] I_RATIO_FAST,
	input wire logic [RATIO_WIDTH-1:0] I_RATIO_PRE,
	output logic O_INDICATOR_A,
	output logic O_INDICATOR_B,
	output logic O_CHARGER_ON,
	output logic [1:0] O_CURRENT_SEL,
	output logic O_RECOVERY_TRICKLE,
	output logic O_THERMAL_REG,
	output logic O_PCHG_FAULT,
	output logic O_TIMER_TICK
);
	cpt_mode_t mode_reg, mode_next;
	cpt_phase_t phase_reg, phase_next;

	logic [1:0] ctrl_reg;
	logic [TMR_WIDTH-1:0] pchg_tc_reg;
	logic [TMR_WIDTH-1:0] count_reg;
	logic ce_n_d_reg;
	logic ce_rise;
	logic fault_reg;
	logic shut_reg;
	logic term_en;
	logic done_shown;
	logic timer_reset;
	logic timer_count;
	logic expired;
	logic fault_clear;
	logic tick;
	logic [RATIO_WIDTH-1:0] ratio_sel;
	logic [RATIO_WIDTH-1:0] stretch_mult;
	logic apb_access;
	logic apb_done;
	logic addr_ok;
	logic [31:0] rdata_next;
	logic ind_a_next;
	logic ind_b_next;
	logic [1:0] cur_next;

	// Combinational phase to current-select decode, used by the current selection
	function automatic logic [1:0] phase_current(input cpt_phase_t p);
		unique case (p)
			PHASE_PRE: phase_current = CUR_PRE;
			PHASE_FAST: phase_current = CUR_FAST;
			PHASE_VREG: phase_current = CUR_VREG;
			default: phase_current = CUR_OFF;
		endcase
	endfunction : phase_current

	function automatic logic valid_addr(input logic [7:0] a);
		valid_addr = (a == ADDR_CTRL) || (a == ADDR_PCHG_TC)
			|| (a == ADDR_STATUS) || (a == ADDR_COUNT);
	endfunction : valid_addr

	// Termination follows the timer pin wiring and a software gate
	assign term_en = !I_TIMER_PROGRAM_OPEN && ctrl_reg[CTRL_TERM_EN_BIT];
	assign done_shown = I_TERM_DONE && term_en;
	assign ce_rise = I_CHARGE_ENABLE_N && !ce_n_d_reg;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ce_n_d_reg <= 1'b1;
		end else begin
			ce_n_d_reg <= I_CHARGE_ENABLE_N;
		end
	end

	// Thermal shutdown with hysteresis: trip high, release only well below
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			shut_reg <= 1'b0;
		end else if (I_TJ_OVER_SHUT) begin
			shut_reg <= 1'b1;
		end else if (I_TJ_BELOW_RESUME) begin
			shut_reg <= 1'b0;
		end
	end

	always_comb begin
		if (!I_POWER_OK) begin
			mode_next = MODE_SLEEP;
		end else if (I_CHARGE_ENABLE_N || I_INPUT_OVERVOLTAGE) begin
			mode_next = MODE_STANDBY;
		end else if (fault_reg || (expired && !I_VOUT_ABOVE_LOWV)) begin
			mode_next = MODE_FAULT;
		end else if (!I_PACK_TEMP_OK || shut_reg || I_TJ_OVER_SHUT) begin
			mode_next = MODE_SUSPEND;
		end else begin
			mode_next = MODE_CHARGING;
		end
	end

	always_comb begin
		if (!I_VOUT_ABOVE_LOWV) begin
			phase_next = PHASE_PRE;
		end else if (I_VOUT_AT_REG) begin
			phase_next = PHASE_VREG;
		end else begin
			phase_next = PHASE_FAST;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			mode_reg <= MODE_SLEEP;
			phase_reg <= PHASE_PRE;
		end else begin
			mode_reg <= mode_next;
			phase_reg <= phase_next;
		end
	end

	// Ratio follows the phase; only applied while thermal loop is active
	assign ratio_sel = (phase_reg == PHASE_PRE) ? I_RATIO_PRE
		: I_RATIO_FAST;
	assign stretch_mult = (O_THERMAL_REG && ctrl_reg[CTRL_STRETCH_EN_BIT])
		? ratio_sel : RATIO_WIDTH'(1);

	// One oscillator feeds both the safety counter and the O_TIMER_TICK output
	cpt_clock_stretch #(
		.DIV_CYCLES(OSC_DIV_CYCLES),
		.MULT_WIDTH(RATIO_WIDTH)
	) u_stretch (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_mult(stretch_mult),
		.o_tick(tick)
	);

	assign O_TIMER_TICK = tick;

	// Pre-charge safety timer on the stretched oscillator
	assign timer_reset = (mode_reg == MODE_STANDBY)
		|| (mode_reg == MODE_SLEEP)
		|| I_TIMER_PROGRAM_OPEN || I_VOUT_ABOVE_LOWV;
	assign expired = (count_reg >= pchg_tc_reg);
	assign timer_count = (mode_reg == MODE_CHARGING) && !I_TIMER_PROGRAM_OPEN
		&& !I_VOUT_ABOVE_LOWV && !expired && tick;

	always_ff @(posedge I_CLK) begin
		if (I_RST || timer_reset) begin
			count_reg <= '0;
		end else if (timer_count) begin
			count_reg <= count_reg + TMR_WIDTH'(1);
		end
		// Below threshold with the pin wired, suspend and fault leave the count untouched
	end

	assign fault_clear = ce_rise || I_INPUT_OVERVOLTAGE || !I_POWER_OK
		|| I_TIMER_PROGRAM_OPEN;

	// A timeout seen in the same cycle as a clear still latches the fault
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			fault_reg <= 1'b0;
		end else if (expired && !I_VOUT_ABOVE_LOWV
			&& mode_reg == MODE_CHARGING) begin
			fault_reg <= 1'b1;
		end else if (fault_clear) begin
			fault_reg <= 1'b0;
		end
	end

	// Status code and current selection from the next mode and phase
	always_comb begin
		ind_a_next = 1'b0;
		ind_b_next = 1'b0;
		cur_next = CUR_OFF;
		if (mode_next == MODE_CHARGING && !I_INPUT_OVERVOLTAGE) begin
			cur_next = phase_current(phase_next);
			if (done_shown) begin
				ind_b_next = 1'b1;
			end else if (phase_next == PHASE_PRE) begin
				ind_a_next = 1'b1;
				ind_b_next = 1'b1;
			end else begin
				ind_a_next = 1'b1;
			end
		end
		// Every other mode leaves both indicators released
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_INDICATOR_A <= 1'b0;
			O_INDICATOR_B <= 1'b0;
			O_CURRENT_SEL <= CUR_OFF;
			O_CHARGER_ON <= 1'b0;
		end else begin
			O_INDICATOR_A <= ind_a_next;
			O_INDICATOR_B <= ind_b_next;
			O_CURRENT_SEL <= cur_next;
			O_CHARGER_ON <= (cur_next != CUR_OFF);
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_RECOVERY_TRICKLE <= 1'b0;
			O_PCHG_FAULT <= 1'b0;
			O_THERMAL_REG <= 1'b0;
		end else begin
			O_RECOVERY_TRICKLE <= fault_reg && I_POWER_OK
				&& !I_VOUT_ABOVE_LOWV;
			O_PCHG_FAULT <= fault_reg;
			// Current reduction itself is analog; this flags the loop
			O_THERMAL_REG <= I_TJ_AT_REG
				&& (mode_next == MODE_CHARGING);
		end
	end

	// APB slave: one wait state, then a registered answer
	assign apb_access = I_PSEL && I_PENABLE;
	assign apb_done = apb_access && O_PREADY;
	assign addr_ok = valid_addr(I_PADDR);

	always_comb begin
		rdata_next = 32'h00000000;
		unique case (I_PADDR)
			ADDR_CTRL: rdata_next[1:0] = ctrl_reg;
			ADDR_PCHG_TC: rdata_next[TMR_WIDTH-1:0] = pchg_tc_reg;
			ADDR_STATUS: begin
				rdata_next[ST_MODE_LSB +: 3] = mode_reg;
				rdata_next[ST_PHASE_LSB +: 2] = phase_reg;
				rdata_next[ST_FAULT_BIT] = fault_reg;
				rdata_next[ST_SHUT_BIT] = shut_reg;
				rdata_next[ST_TREG_BIT] = O_THERMAL_REG;
				rdata_next[ST_IND_A_BIT] = O_INDICATOR_A;
				rdata_next[ST_IND_B_BIT] = O_INDICATOR_B;
				rdata_next[ST_TRICKLE_BIT] = O_RECOVERY_TRICKLE;
			end
			ADDR_COUNT: rdata_next[TMR_WIDTH-1:0] = count_reg;
			default: rdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h00000000;
			O_PSLVERR <= 1'b0;
		end else if (apb_access && !O_PREADY) begin
			O_PREADY <= 1'b1;
			O_PRDATA <= I_PWRITE ? 32'h00000000 : rdata_next;
			O_PSLVERR <= !addr_ok;
		end else begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h00000000;
			O_PSLVERR <= 1'b0;
		end
	end

	// Writes land on the completing edge; status and count are read-only
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ctrl_reg <= CTRL_RESET;
			pchg_tc_reg <= PCHG_TC_DEFAULT;
		end else if (apb_done && I_PWRITE) begin
			if (I_PADDR == ADDR_CTRL) begin
				ctrl_reg <= I_PWDATA[1:0];
			end
			// A zero terminal count would fault at once; keep it nonzero
			if (I_PADDR == ADDR_PCHG_TC && I_PWDATA[TMR_WIDTH-1:0] != '0) begin
				pchg_tc_reg <= I_PWDATA[TMR_WIDTH-1:0];
			end
		end
	end
endmodule : cpt_charge_ctrl

/* testbench/cpt_properties.sv */
// Concurrent checks on the charge controller ports.
// Assumes one clock and the synchronous active-high reset.
module cpt_properties
	import cpt_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_POWER_OK,
	input wire logic I_INPUT_OVERVOLTAGE,
	input wire logic I_CHARGE_ENABLE_N,
	input wire logic I_TIMER_PROGRAM_OPEN,
	input wire logic I_VOUT_ABOVE_LOWV,
	input wire logic I_VOUT_AT_REG,
	input wire logic I_PACK_TEMP_OK,
	input wire logic I_TJ_OVER_SHUT,
	input wire logic I_TJ_BELOW_RESUME,
	input wire logic O_INDICATOR_A,
	input wire logic O_INDICATOR_B,
	input wire logic O_CHARGER_ON,
	input wire logic [1:0] O_CURRENT_SEL,
	input wire logic O_PCHG_FAULT
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	wire logic off = !I_POWER_OK || I_INPUT_OVERVOLTAGE || I_CHARGE_ENABLE_N;
	// Three quiet cycles let the thermal latch release first
	wire logic run = !off && I_PACK_TEMP_OK && !I_TJ_OVER_SHUT
		&& I_TJ_BELOW_RESUME && !O_PCHG_FAULT;
	property p_both_on;
		O_INDICATOR_A && O_INDICATOR_B |-> O_CURRENT_SEL == CUR_PRE;
	endproperty
	a_both_on: assert property (p_both_on)
		else $error("both indicators outside precharge");
	property p_a_only;
		O_INDICATOR_A && !O_INDICATOR_B |-> O_CURRENT_SEL[1];
	endproperty
	a_a_only: assert property (p_a_only)
		else $error("fast code without fast current");
	property p_off;
		$past(off) |-> !O_INDICATOR_A && !O_INDICATOR_B
			&& O_CURRENT_SEL == CUR_OFF;
	endproperty
	a_off: assert property (p_off)
		else $error("charger off but outputs active");
	property p_fast_sel;
		(run && I_VOUT_ABOVE_LOWV && !I_VOUT_AT_REG)[*3]
			|=> O_CURRENT_SEL == CUR_FAST;
	endproperty
	a_fast_sel: assert property (p_fast_sel)
		else $error("fast current not selected");
	property p_pre_sel;
		// On expiry the current drops a cycle before the fault output rises
		(run && !I_VOUT_ABOVE_LOWV)[*3]
			|=> (O_CURRENT_SEL == CUR_PRE) or (##1 O_PCHG_FAULT);
	endproperty
	a_pre_sel: assert property (p_pre_sel)
		else $error("precharge current not selected");
	property p_vreg_sel;
		(run && I_VOUT_AT_REG)[*3] |=> O_CURRENT_SEL == CUR_VREG;
	endproperty
	a_vreg_sel: assert property (p_vreg_sel)
		else $error("regulation phase not entered");
	property p_fault_off;
		$rose(O_PCHG_FAULT) |-> O_CURRENT_SEL == CUR_OFF && !O_CHARGER_ON;
	endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("fault left charger on");
	property p_fault_clr;
		I_INPUT_OVERVOLTAGE || !I_POWER_OK || I_TIMER_PROGRAM_OPEN
			|-> ##[1:2] !O_PCHG_FAULT;
	endproperty
	a_fault_clr: assert property (p_fault_clr)
		else $error("fault latch not cleared");
endmodule : cpt_properties

bind cpt_charge_ctrl cpt_properties chk_i (.*);

/* testbench/cpt_pack_model.sv */
// Battery pack model: turns the cell voltage into comparator levels.
// Assumes the bench moves the cell voltage; the cell holds it otherwise.
module cpt_pack_model #(
	parameter int LOWV_MV = 2950,
	parameter int REG_MV = 4000
) (
	input wire logic i_clk,
	input wire logic [12:0] i_mv,
	output logic o_above_lowv,
	output logic o_at_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered, as a sampled comparator front end would be
	always_ff @(posedge i_clk) begin
		o_above_lowv <= i_mv > LOWV_MV;
		o_at_reg <= i_mv >= REG_MV;
	end
endmodule : cpt_pack_model

/* testbench/tb_top.sv */
// Bench for the charge controller: APB access plus pin scenarios.
// Assumes the pack model supplies the output voltage comparators.
module tb_top
	import cpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] TC = 24'h000003;
	localparam logic [12:0] LO = 13'h03E8;
	localparam logic [12:0] HI = 13'h0DAC;
	logic I_CLK = 1'h0, I_RST = 1'h1, I_PSEL = 1'h0, I_PENABLE = 1'h0;
	logic I_PWRITE = 1'h0;
	logic [7:0] I_PADDR = 8'h00;
	logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
	logic O_PREADY, O_PSLVERR, O_INDICATOR_A, O_INDICATOR_B, O_CHARGER_ON;
	logic O_RECOVERY_TRICKLE, O_THERMAL_REG, O_PCHG_FAULT, O_TIMER_TICK, er;
	logic [1:0] O_CURRENT_SEL;
	logic I_POWER_OK = 1'h0, I_INPUT_OVERVOLTAGE = 1'h0;
	logic I_CHARGE_ENABLE_N = 1'h1, I_TIMER_PROGRAM_OPEN = 1'h0;
	logic I_PACK_TEMP_OK = 1'h1, I_TJ_AT_REG = 1'h0, I_TJ_OVER_SHUT = 1'h0;
	logic I_TJ_BELOW_RESUME = 1'h1, I_TERM_DONE = 1'h0;
	logic I_VOUT_ABOVE_LOWV, I_VOUT_AT_REG;
	logic [3:0] I_RATIO_FAST = 4'h1, I_RATIO_PRE = 4'h1;
	logic [12:0] mv = LO;
	int fail_count = 0, checks_done = 0, cyc = 0, n;
	wire logic [3:0] st = {O_INDICATOR_A, O_INDICATOR_B, O_CURRENT_SEL};
	cpt_charge_ctrl #(.PCHG_TC_DEFAULT(TC)) dut (.*);
	cpt_pack_model pack (.i_clk(I_CLK), .i_mv(mv),
		.o_above_lowv(I_VOUT_ABOVE_LOWV), .o_at_reg(I_VOUT_AT_REG));
	task complete_run;
		$display("checks=%0d errors=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task w(input int c);
		repeat (c) @(posedge I_CLK);
	endtask : w
	// No fixed wait: the answer edge is whatever PREADY says
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_PSEL <= 1'h1;
		I_PWRITE <= wr;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_CLK);
		I_PENABLE <= 1'h1;
		do @(posedge I_CLK); while (O_PREADY !== 1'h1);
		rd = O_PRDATA;
		er = O_PSLVERR;
		I_PSEL <= 1'h0;
		I_PENABLE <= 1'h0;
	endtask : apb
	// First interval after a ratio change may be short, so use the second
	task gap(input int exp);
		while (O_TIMER_TICK !== 1'h1) @(posedge I_CLK);
		repeat (2) begin
			n = 0;
			do begin
				@(posedge I_CLK);
				n++;
			end while (O_TIMER_TICK !== 1'h1);
		end
		chk(n, exp);
	endtask : gap
	initial begin
		forever #4 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		w(10);
		I_RST <= 1'h0;
		apb(1'h0, ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RESET);
		apb(1'h0, ADDR_PCHG_TC, 32'h0);
		chk(rd, TC);
		apb(1'h0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		gap(OSC_DIV_CYCLES);
		I_POWER_OK <= 1'h1;
		I_CHARGE_ENABLE_N <= 1'h0;
		w(4);
		chk(st, {2'h3, CUR_PRE});
		w(150);
		I_PACK_TEMP_OK <= 1'h0;
		w(4);
		chk(st, {2'h0, CUR_OFF});
		apb(1'h0, ADDR_COUNT, 32'h0);
		n = rd;
		chk(rd != 32'h0, 1'h1);
		w(300);
		apb(1'h0, ADDR_COUNT, 32'h0);
		chk(rd, n);
		mv <= HI;
		w(4);
		apb(1'h0, ADDR_COUNT, 32'h0);
		chk(rd, 32'h0);
		mv <= LO;
		I_PACK_TEMP_OK <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			while (O_PCHG_FAULT !== 1'h1) @(posedge I_CLK);
			apb(1'h0, ADDR_COUNT, 32'h0);
			chk(rd, TC);
			chk({O_CHARGER_ON, O_CURRENT_SEL, O_RECOVERY_TRICKLE}, 4'h1);
			case (k)
				0: I_CHARGE_ENABLE_N <= 1'h1;
				1: I_INPUT_OVERVOLTAGE <= 1'h1;
				2: I_POWER_OK <= 1'h0;
				default: I_TIMER_PROGRAM_OPEN <= 1'h1;
			endcase
			w(3);
			chk(O_PCHG_FAULT, 1'h0);
			if (k < 3) chk(st, 4'h0);
			apb(1'h0, ADDR_COUNT, 32'h0);
			chk(rd, 32'h0);
			I_CHARGE_ENABLE_N <= 1'h0;
			I_INPUT_OVERVOLTAGE <= 1'h0;
			I_POWER_OK <= 1'h1;
			I_TIMER_PROGRAM_OPEN <= 1'h0;
		end
		mv <= HI;
		w(4);
		chk(st, {2'h2, CUR_FAST});
		mv <= 13'h0FA0;
		w(4);
		chk(st, {2'h2, CUR_VREG});
		I_TERM_DONE <= 1'h1;
		w(3);
		chk(st[3:2], 2'h1);
		apb(1'h1, ADDR_CTRL, 32'h2);
		w(3);
		chk(st[3:2], 2'h2);
		I_TERM_DONE <= 1'h0;
		mv <= HI;
		I_TJ_AT_REG <= 1'h1;
		I_RATIO_FAST <= 4'h3;
		w(4);
		chk(O_THERMAL_REG, 1'h1);
		gap(3 * OSC_DIV_CYCLES);
		apb(1'h1, ADDR_PCHG_TC, 32'h10);
		apb(1'h0, ADDR_PCHG_TC, 32'h0);
		chk(rd, 32'h10);
		mv <= LO;
		I_RATIO_PRE <= 4'h2;
		gap(2 * OSC_DIV_CYCLES);
		I_TJ_AT_REG <= 1'h0;
		mv <= HI;
		I_TJ_OVER_SHUT <= 1'h1;
		I_TJ_BELOW_RESUME <= 1'h0;
		w(4);
		chk(O_CURRENT_SEL, CUR_OFF);
		I_TJ_OVER_SHUT <= 1'h0;
		w(4);
		chk(O_CURRENT_SEL, CUR_OFF);
		I_TJ_BELOW_RESUME <= 1'h1;
		w(4);
		chk(O_CURRENT_SEL, CUR_FAST);
		complete_run();
	end
endmodule : tb_top
